// ---- shared/crsf_pkg.sv ----
/*
 package for the cpu register set and flag block: flag bit positions,
 reset values, timer codes and the software register map.
 assumes nothing of its surroundings.
*/
package crsf_pkg;
   // status register bit positions
   localparam int FLAG_CARRY_POS  = 0;
   localparam int FLAG_IRQ_POS    = 1;
   localparam int FLAG_ZERO_POS   = 2;
   localparam int FLAG_OVF_POS    = 3;
   localparam int FLAG_HALF_POS   = 4;
   // mask of the writable status bits
   localparam logic [7:0] FLAG_USED_MASK = 8'h1f;
   // reset values
   localparam logic [15:0] PTR_RESET   = 16'h0000;
   localparam logic [7:0]  BYTE_RESET  = 8'h00;
   localparam logic [8:0]  TIMER_ZERO  = 9'h000;
   localparam logic [8:0]  TIMER_FULL  = 9'h1ff;
   // register select codes for the load and read ports
   localparam logic [3:0] SEL_ACC    = 4'h0;
   localparam logic [3:0] SEL_P1_LO  = 4'h1;
   localparam logic [3:0] SEL_P1_HI  = 4'h2;
   localparam logic [3:0] SEL_P2_LO  = 4'h3;
   localparam logic [3:0] SEL_P2_HI  = 4'h4;
   localparam logic [3:0] SEL_P3_LO  = 4'h5;
   localparam logic [3:0] SEL_P3_HI  = 4'h6;
   localparam logic [3:0] SEL_FLAGS  = 4'h7;
   localparam logic [3:0] SEL_TIM_LO = 4'h8;
   localparam logic [3:0] SEL_TIM_HI = 4'h9;
   localparam logic [3:0] SEL_IP_LO  = 4'ha;
   localparam logic [3:0] SEL_IP_HI  = 4'hb;
   localparam logic [3:0] SEL_SP_LO  = 4'hc;
   localparam logic [3:0] SEL_SP_HI  = 4'hd;
   localparam logic [3:0] SEL_MISC   = 4'he;
   localparam logic [3:0] SEL_EVENT  = 4'hf;
   // misc register bit positions
   localparam int MISC_FLOP1_POS = 0;
   localparam int MISC_FLOP2_POS = 1;
   localparam int MISC_LCD_POS   = 2;
   // event status and mask layout
   localparam int EVT_TIMER_POS  = 0;
   localparam int EVT_WIDTH      = 1;
   // alu operation codes
   typedef enum logic [1:0] {
      CRSF_OP_ADD = 2'b00,
      CRSF_OP_ADC = 2'b01,
      CRSF_OP_SUB = 2'b10,
      CRSF_OP_SBC = 2'b11
   } crsf_op_t;
endpackage

// ---- core/crsf_core.sv ----
/*
 cpu register set and condition flags: pointers, accumulator, general
 registers, nine bit timer, loose flops and the status register.
 assumes a sequencer drives the strobes synchronous to core_clk, and a
 plain register port with read data one cycle after the read strobe.
*/
`timescale 1ns/100ps
module crsf_core
   import crsf_pkg::*;
(
   // clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [7:0]  reg_rdata,
   // sequencer controls
   input  wire logic        fetch_byte,
   input  wire logic        ip_load,
   input  wire logic [15:0] ip_value,
   input  wire logic        sp_load,
   input  wire logic [15:0] sp_value,
   input  wire logic        ptr_load,
   input  wire logic [1:0]  ptr_sel,
   input  wire logic [15:0] ptr_value,
   input  wire logic        mem_load,
   input  wire logic [7:0]  mem_data,
   input  wire logic        timer_tick,
   // alu request
   input  wire logic        alu_go,
   input  wire crsf_op_t    alu_op,
   input  wire logic [7:0]  alu_operand,
   // state outputs
   output logic [15:0] ip_out,
   output logic [15:0] sp_out,
   output logic [7:0]  acc_out,
   output logic [15:0] pointer_one,
   output logic [15:0] pointer_two,
   output logic [15:0] pointer_three,
   output logic [7:0]  condition_flags,
   output logic [8:0]  nine_bit_counter,
   output logic        general_flop_one,
   output logic        general_flop_two,
   output logic        lcd_on_bit,
   output logic        timer_irq_req,
   output logic        irq
);
   // register state
   logic [15:0] ip_q;                 // instruction pointer
   logic [15:0] sp_q;                 // stack pointer
   logic [7:0]  acc_q;                // accumulator
   logic [7:0]  gen_q [6];            // six general bytes
   logic [4:0]  flags_q;              // live status bits
   logic [8:0]  tim_q;                // timer counter
   logic        run_q;                // timer running
   logic [2:0]  misc_q;               // flops and lcd bit
   logic [EVT_WIDTH-1:0] evt_q;       // sticky events
   logic [EVT_WIDTH-1:0] mask_q;      // event mask
   logic        full_q;               // timer was full last cycle
   logic [7:0]  rdata_q;              // read data

   // alu result with carries
   function automatic logic [11:0] alu_calc(input crsf_op_t op, input logic [7:0] a,
                                            input logic [7:0] b, input logic cin);
      logic [7:0] bb;
      logic       ci;
      logic [4:0] lo;
      logic [7:0] low7;
      logic [8:0] full;
      bb = b;
      ci = 1'b0;
      lo = 5'h00;
      low7 = 8'h00;
      full = 9'h000;
      unique case (op)
         CRSF_OP_ADD: begin bb = b;  ci = 1'b0; end
         CRSF_OP_ADC: begin bb = b;  ci = cin;  end
         CRSF_OP_SUB: begin bb = ~b; ci = 1'b1; end
         CRSF_OP_SBC: begin bb = ~b; ci = cin;  end
      endcase
      lo   = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
      low7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
      full = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
      // {carry7, carry6, half, result}
      alu_calc = {full[8], low7[7], lo[4], 1'b0, full[7:0]};
   endfunction

   logic [11:0] alu_res;
   logic [4:0]  flags_d;
   assign alu_res = alu_calc(alu_op, acc_q, alu_operand, flags_q[FLAG_CARRY_POS]);

   // next flag set from the alu
   always_comb begin
      flags_d = flags_q;
      flags_d[FLAG_CARRY_POS] = alu_res[11];
      flags_d[FLAG_HALF_POS]  = alu_res[9];
      flags_d[FLAG_ZERO_POS]  = (alu_res[7:0] == BYTE_RESET);
      flags_d[FLAG_OVF_POS]   = alu_res[10] ^ alu_res[11];
      flags_d[FLAG_IRQ_POS]   = flags_q[FLAG_IRQ_POS];
   end

   // register write decode
   logic wr_acc, wr_flags, wr_tim_lo, wr_tim_hi, wr_misc, wr_mask;
   assign wr_acc    = reg_write && reg_addr == SEL_ACC;
   assign wr_flags  = reg_write && reg_addr == SEL_FLAGS;
   assign wr_tim_lo = reg_write && reg_addr == SEL_TIM_LO;
   assign wr_tim_hi = reg_write && reg_addr == SEL_TIM_HI;
   assign wr_misc   = reg_write && reg_addr == SEL_MISC;
   assign wr_mask   = reg_write && reg_addr == SEL_EVENT;

   // instruction pointer
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ip_q <= PTR_RESET;
      end else if (clk_en) begin
         if (ip_load) begin
            ip_q <= ip_value;
         end else if (fetch_byte) begin
            ip_q <= ip_q + 16'h0001;
         end else if (reg_write && reg_addr == SEL_IP_LO) begin
            ip_q[7:0] <= reg_wdata;
         end else if (reg_write && reg_addr == SEL_IP_HI) begin
            ip_q[15:8] <= reg_wdata;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sp_q <= PTR_RESET;
      end else if (clk_en) begin
         if (sp_load) begin
            sp_q <= sp_value;
         end else if (reg_write && reg_addr == SEL_SP_LO) begin
            sp_q[7:0] <= reg_wdata;
         end else if (reg_write && reg_addr == SEL_SP_HI) begin
            sp_q[15:8] <= reg_wdata;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         acc_q <= BYTE_RESET;
      end else if (clk_en) begin
         if (alu_go) begin
            acc_q <= alu_res[7:0];
         end else if (mem_load) begin
            acc_q <= mem_data;
         end else if (wr_acc) begin
            acc_q <= reg_wdata;
         end
      end
   end

   // general registers, bytes and pairs
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 6; i++) begin
            gen_q[i] <= BYTE_RESET;
         end
      end else if (clk_en) begin
         if (ptr_load && ptr_sel != 2'b11) begin
            gen_q[{ptr_sel, 1'b0}] <= ptr_value[7:0];
            gen_q[{ptr_sel, 1'b1}] <= ptr_value[15:8];
         end else if (reg_write && reg_addr >= SEL_P1_LO && reg_addr <= SEL_P3_HI) begin
            gen_q[3'(reg_addr - SEL_P1_LO)] <= reg_wdata;
         end
      end
   end

   // status register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         flags_q <= 5'h00;
      end else if (clk_en) begin
         if (alu_go) begin
            flags_q <= flags_d;
         end else if (wr_flags) begin
            flags_q <= reg_wdata[4:0];
         end
      end
   end

   // nine bit value a timer byte write leaves behind
   logic [8:0] tim_load;
   assign tim_load = wr_tim_lo ? {tim_q[8], reg_wdata} : {reg_wdata[0], tim_q[7:0]};

   // timer counter and run state
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tim_q <= TIMER_ZERO;
         run_q <= 1'b0;
      end else if (clk_en) begin
         if (wr_tim_lo || wr_tim_hi) begin
            tim_q <= tim_load;
            run_q <= (tim_load != TIMER_ZERO);
         end else if (run_q && timer_tick) begin
            tim_q <= tim_q + 9'h001;
         end
      end
   end

   // loose flops and lcd bit
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         misc_q <= 3'h0;
      end else if (clk_en && wr_misc) begin
         misc_q <= reg_wdata[2:0];
      end
   end

   // timer full edge and sticky event
   logic full_now;
   assign full_now = (tim_q == TIMER_FULL);
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         full_q <= 1'b0;
         evt_q  <= '0;
         mask_q <= '0;
      end else if (clk_en) begin
         full_q <= full_now;
         if (wr_mask) begin
            mask_q <= reg_wdata[EVT_WIDTH-1:0];
         end
         // set wins over read clear
         if (timer_irq_req) begin
            evt_q[EVT_TIMER_POS] <= 1'b1;
         end else if (reg_read && reg_addr == SEL_EVENT) begin
            evt_q <= '0;
         end
      end
   end

   assign timer_irq_req = full_now && !full_q && flags_q[FLAG_IRQ_POS];
   assign irq           = |(evt_q & mask_q);

   // read data, one cycle later
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= BYTE_RESET;
      end else if (clk_en) begin
         rdata_q <= BYTE_RESET;
         if (reg_read) begin
            unique case (reg_addr)
               SEL_ACC:    rdata_q <= acc_q;
               SEL_P1_LO, SEL_P1_HI, SEL_P2_LO, SEL_P2_HI, SEL_P3_LO, SEL_P3_HI:
                  rdata_q <= gen_q[3'(reg_addr - SEL_P1_LO)];
               SEL_FLAGS:  rdata_q <= {3'h0, flags_q};
               SEL_TIM_LO: rdata_q <= tim_q[7:0];
               SEL_TIM_HI: rdata_q <= {6'h00, run_q, tim_q[8]};
               SEL_IP_LO:  rdata_q <= ip_q[7:0];
               SEL_IP_HI:  rdata_q <= ip_q[15:8];
               SEL_SP_LO:  rdata_q <= sp_q[7:0];
               SEL_SP_HI:  rdata_q <= sp_q[15:8];
               SEL_MISC:   rdata_q <= {5'h00, misc_q};
               SEL_EVENT:  rdata_q <= {7'h00, evt_q};
            endcase
         end
      end
   end

   // outputs
   assign reg_rdata        = rdata_q;
   assign ip_out           = ip_q;
   assign sp_out           = sp_q;
   assign acc_out          = acc_q;
   assign pointer_one      = {gen_q[1], gen_q[0]};
   assign pointer_two      = {gen_q[3], gen_q[2]};
   assign pointer_three    = {gen_q[5], gen_q[4]};
   assign condition_flags  = {3'h0, flags_q};
   assign nine_bit_counter = tim_q;
   assign general_flop_one = misc_q[MISC_FLOP1_POS];
   assign general_flop_two = misc_q[MISC_FLOP2_POS];
   assign lcd_on_bit       = misc_q[MISC_LCD_POS];

   chk_ip_step: assert property (@(posedge core_clk) disable iff (!resetn)
      clk_en && fetch_byte && !ip_load |=> ip_q == $past(ip_q) + 16'h0001)
      else $error("ip did not step");
   chk_sp_load: assert property (@(posedge core_clk) disable iff (!resetn)
      clk_en && sp_load |=> sp_q == $past(sp_value))
      else $error("sp load lost");
   chk_timer_stop: assert property (@(posedge core_clk) disable iff (!resetn)
      clk_en && wr_tim_lo && reg_wdata == 8'h00 && tim_q[8] == 1'b0
      |=> !run_q && tim_q == TIMER_ZERO)
      else $error("timer runs after zero load");
   chk_timer_hold: assert property (@(posedge core_clk) disable iff (!resetn)
      clk_en && !run_q && !wr_tim_lo && !wr_tim_hi |=> $stable(tim_q))
      else $error("stopped timer moved");
   chk_timer_run: assert property (@(posedge core_clk) disable iff (!resetn)
      clk_en && wr_tim_lo && reg_wdata != 8'h00 |=> run_q)
      else $error("timer idle after load");
   chk_timer_irq: assert property (@(posedge core_clk) disable iff (!resetn)
      clk_en && timer_irq_req |=> evt_q[EVT_TIMER_POS])
      else $error("timer event lost");
   chk_enable_kept: assert property (@(posedge core_clk) disable iff (!resetn)
      clk_en && alu_go |=> $stable(flags_q[FLAG_IRQ_POS]))
      else $error("alu touched enable");
   chk_zero_flag: assert property (@(posedge core_clk) disable iff (!resetn)
      clk_en && alu_go |=> flags_q[FLAG_ZERO_POS] == (acc_q == 8'h00))
      else $error("zero flag wrong");
   chk_add_carry: assert property (@(posedge core_clk) disable iff (!resetn)
      clk_en && alu_go && alu_op == CRSF_OP_ADD
      |=> flags_q[FLAG_CARRY_POS] == ((9'($past(acc_q)) + 9'($past(alu_operand))) > 9'h0ff))
      else $error("add carry wrong");
   chk_sub_carry: assert property (@(posedge core_clk) disable iff (!resetn)
      clk_en && alu_go && alu_op == CRSF_OP_SUB
      |=> flags_q[FLAG_CARRY_POS] == ($past(acc_q) >= $past(alu_operand)))
      else $error("sub borrow wrong");
endmodule

// ---- verification/test_cpu_register_set_and_flags.sv ----
/*
 self-checking bench for the register set and condition flag block.
 assumes the block has no far-side partner: the bench drives every port.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin miscompares++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module test_cpu_register_set_and_flags
   import crsf_pkg::*;
;
   // clock, reset, enable
   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        clk_en = 1'b1;
   // register port
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic [7:0]  reg_rdata;
   // sequencer controls
   logic        fetch_byte = 1'b0, ip_load = 1'b0, sp_load = 1'b0, ptr_load = 1'b0;
   logic        mem_load = 1'b0, timer_tick = 1'b0, alu_go = 1'b0;
   logic [15:0] ip_value = 16'h0000, sp_value = 16'h0000, ptr_value = 16'h0000;
   logic [1:0]  ptr_sel = 2'h0;
   logic [7:0]  mem_data = 8'h00, alu_operand = 8'h00;
   crsf_op_t    alu_op = CRSF_OP_ADD;
   // outputs
   logic [15:0] ip_out, sp_out, pointer_one, pointer_two, pointer_three;
   logic [7:0]  acc_out, condition_flags;
   logic [8:0]  nine_bit_counter;
   logic        general_flop_one, general_flop_two, lcd_on_bit, timer_irq_req, irq;
   // bench state
   int          miscompares = 0;
   int          checks_done = 0;
   int          seed = 32'h72e30e72;
   logic [15:0] v, w;
   logic [7:0]  a, b, f;
   logic [1:0]  op;
   logic [15:0] ptrs [3];

   crsf_core dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .fetch_byte(fetch_byte),
      .ip_load(ip_load), .ip_value(ip_value), .sp_load(sp_load), .sp_value(sp_value),
      .ptr_load(ptr_load), .ptr_sel(ptr_sel), .ptr_value(ptr_value),
      .mem_load(mem_load), .mem_data(mem_data), .timer_tick(timer_tick),
      .alu_go(alu_go), .alu_op(alu_op), .alu_operand(alu_operand), .ip_out(ip_out),
      .sp_out(sp_out), .acc_out(acc_out), .pointer_one(pointer_one),
      .pointer_two(pointer_two), .pointer_three(pointer_three),
      .condition_flags(condition_flags), .nine_bit_counter(nine_bit_counter),
      .general_flop_one(general_flop_one), .general_flop_two(general_flop_two),
      .lcd_on_bit(lcd_on_bit), .timer_irq_req(timer_irq_req), .irq(irq));

   // free-running clock, 10 ns period
   always #5 core_clk = ~core_clk;

   // expected {acc, flags} of one alu step, carries worked out from 4, 7 and 8 bit sums
   function automatic logic [15:0] alu_exp(input logic [1:0] o, input logic [7:0] x,
                                           input logic [7:0] y, input logic [7:0] fl);
      logic [7:0] yy;
      logic       ci;
      logic [8:0] s;
      logic [4:0] lo;
      logic [7:0] s6;
      yy = o[1] ? ~y : y;
      ci = (o == 2'd2) ? 1'b1 : ((o == 2'd0) ? 1'b0 : fl[FLAG_CARRY_POS]);
      s = x + yy + ci;
      lo = x[3:0] + yy[3:0] + ci;
      s6 = x[6:0] + yy[6:0] + ci;
      alu_exp = {s[7:0], 3'b000, lo[4], s6[7] ^ s[8], s[7:0] == 8'h00,
                 fl[FLAG_IRQ_POS], s[8]};
   endfunction

   // verdict and end of run
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // one register write, taken at the second edge
   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      #1;
   endtask

   // one register read, data compared in the cycle after the strobe
   task automatic rd(input logic [3:0] ad, input logic [7:0] e, input string n);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      `CHK(n, e, reg_rdata)
   endtask

   // one edge with the given pulse inputs high for a single cycle
   task automatic pulse(input logic fb, input logic ml, input logic tt, input logic ag);
      @(posedge core_clk);
      fetch_byte <= fb;
      mem_load <= ml;
      timer_tick <= tt;
      alu_go <= ag;
      @(posedge core_clk);
      {fetch_byte, mem_load, timer_tick, alu_go} <= 4'h0;
      #1;
   endtask

   // alu step from a given accumulator and flag byte
   task automatic alu_case(input logic [1:0] o, input logic [7:0] x, input logic [7:0] y,
                           input logic [7:0] fl);
      wr(SEL_FLAGS, fl);
      mem_data <= x;
      pulse(1'b0, 1'b1, 1'b0, 1'b0);
      alu_op <= crsf_op_t'(o);
      alu_operand <= y;
      pulse(1'b0, 1'b0, 1'b0, 1'b1);
      w = alu_exp(o, x, y, fl & FLAG_USED_MASK);
      `CHK("acc", w[15:8], acc_out)
      `CHK("flags", w[7:0], condition_flags)
   endtask

   // timer run up to all ones under a given enable and mask
   task automatic timer_hit(input logic en, input logic mk, input logic ei,
                            input logic [7:0] es);
      wr(SEL_FLAGS, {6'h00, en, 1'b0});
      wr(SEL_EVENT, {7'h00, mk});
      wr(SEL_TIM_HI, 8'h01);
      wr(SEL_TIM_LO, 8'hfe);
      pulse(1'b0, 1'b0, 1'b1, 1'b0);
      `CHK("counter", TIMER_FULL, nine_bit_counter)
      `CHK("irq request", en, timer_irq_req)
      @(posedge core_clk);
      #1;
      `CHK("irq", ei, irq)
      rd(SEL_EVENT, es, "event");
      `CHK("irq after read", 1'b0, irq)
   endtask

   // bound on the whole run
   initial begin
      #1000000;
      miscompares++;
      test_done();
   end

   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      `CHK("flags reset", 8'h00, condition_flags)
      `CHK("ip reset", PTR_RESET, ip_out)
      // status layout: upper three bits read zero
      wr(SEL_FLAGS, 8'hff);
      rd(SEL_FLAGS, 8'h1f, "flags read");
      // byte registers and their pairing
      for (int i = 0; i < 6; i++) begin
         a = $random(seed);
         wr(SEL_P1_LO + i[3:0], a);
         rd(SEL_P1_LO + i[3:0], a, "byte reg");
         ptrs[i / 2][(i % 2) * 8 +: 8] = a;
      end
      `CHK("pair one", ptrs[0], pointer_one)
      `CHK("pair two", ptrs[1], pointer_two)
      `CHK("pair three", ptrs[2], pointer_three)
      for (int i = 0; i < 3; i++) begin
         v = $random(seed);
         @(posedge core_clk);
         ptr_load <= 1'b1;
         ptr_sel <= i[1:0];
         ptr_value <= v;
         pulse(1'b0, 1'b0, 1'b0, 1'b0);
         ptr_load <= 1'b0;
         rd(SEL_P1_LO + 4'(2 * i), v[7:0], "pair low");
         rd(SEL_P1_HI + 4'(2 * i), v[15:8], "pair high");
      end
      // instruction pointer load then byte fetches, back to back
      v = 16'hfffd;
      @(posedge core_clk);
      ip_load <= 1'b1;
      ip_value <= v;
      sp_load <= 1'b1;
      sp_value <= 16'h8a5c;
      pulse(1'b0, 1'b0, 1'b0, 1'b0);
      {ip_load, sp_load} <= 2'b00;
      `CHK("sp", 16'h8a5c, sp_out)
      wr(SEL_SP_LO, 8'h3c);
      rd(SEL_SP_HI, 8'h8a, "sp high");
      rd(SEL_SP_LO, 8'h3c, "sp low");
      @(posedge core_clk);
      fetch_byte <= 1'b1;
      repeat (5) @(posedge core_clk);
      fetch_byte <= 1'b0;
      #1;
      `CHK("ip", v + 16'd5, ip_out)
      rd(SEL_IP_LO, 8'(v + 16'd5), "ip low");
      // alu corner cases: half carry, overflow, carry and zero, borrow
      alu_case(2'd0, 8'h0f, 8'h01, 8'h02);
      alu_case(2'd0, 8'h7f, 8'h01, 8'h00);
      alu_case(2'd0, 8'hff, 8'h01, 8'h02);
      alu_case(2'd2, 8'h33, 8'h33, 8'h00);
      alu_case(2'd2, 8'h00, 8'h01, 8'h03);
      alu_case(2'd2, 8'h80, 8'h01, 8'h00);
      alu_case(2'd1, 8'hff, 8'h00, 8'h01);
      alu_case(2'd3, 8'h10, 8'h10, 8'h00);
      // random alu traffic over all four operations
      for (int i = 0; i < 60; i++) begin
         op = $random(seed);
         a = $random(seed);
         b = $random(seed);
         f = $random(seed);
         alu_case(op, a, b, f);
      end
      // zero load stops the timer
      wr(SEL_TIM_HI, 8'h00);
      wr(SEL_TIM_LO, 8'h00);
      repeat (3) pulse(1'b0, 1'b0, 1'b1, 1'b0);
      `CHK("timer stopped", TIMER_ZERO, nine_bit_counter)
      rd(SEL_TIM_HI, 8'h00, "timer run");
      // non-zero load starts it
      wr(SEL_TIM_LO, 8'h21);
      rd(SEL_TIM_HI, 8'h02, "timer run");
      pulse(1'b0, 1'b0, 1'b1, 1'b0);
      `CHK("timer step", 9'h022, nine_bit_counter)
      rd(SEL_TIM_LO, 8'h22, "timer low");
      // event unmasked, masked and with enable clear
      timer_hit(1'b1, 1'b1, 1'b1, 8'h01);
      timer_hit(1'b1, 1'b0, 1'b0, 8'h01);
      timer_hit(1'b0, 1'b1, 1'b0, 8'h00);
      // loose flops, then a write ignored while the enable is low
      f = $random(seed);
      wr(SEL_MISC, {5'h00, f[2:0]});
      `CHK("flops", f[2:0], {lcd_on_bit, general_flop_two, general_flop_one})
      clk_en <= 1'b0;
      wr(SEL_ACC, 8'h5a);
      `CHK("acc frozen", w[15:8], acc_out)
      clk_en <= 1'b1;
      wr(SEL_ACC, 8'ha5);
      rd(SEL_ACC, 8'ha5, "acc");
      test_done();
   end
endmodule
